// *** dcmt_pkg.sv ***
// Package for the daisy-chain message timing block: timing constants and states.
// Assumes a single 25 MHz clock drives every timer that uses these counts.
package dcmt_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

    // Times in ns for spacing, repeater delay and read latency, else in us or ms.
    localparam int RESP_SPACING_NS     = 4000;
    localparam int RESP_SPACING_MIN_NS = 3800;
    localparam int RESP_SPACING_MAX_NS = 4250;
    localparam int FWD_DELAY_MAX_NS    = 950;
    localparam int READ_LAT_TYP_NS     = 5000;
    localparam int READ_LAT_MIN_NS     = 4000;
    localparam int READ_LAT_MAX_NS     = 9000;
    localparam int FRAME_TIMEOUT_US    = 250;
    localparam int FRAME_TIMEOUT_MIN_US = 238;
    localparam int COMM_LOSS_MS        = 1024;

    // Cycle counts derived from the times.
    localparam int RESP_SPACING_CYC = RESP_SPACING_NS / CLK_NS;
    localparam int FWD_DELAY_CYC    = FWD_DELAY_MAX_NS / CLK_NS;
    localparam int READ_LAT_CYC     = READ_LAT_TYP_NS / CLK_NS;
    localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * 1000 / CLK_NS;
    localparam longint COMM_LOSS_CYC = longint'(COMM_LOSS_MS) * 64'd1_000_000 / CLK_NS;

    localparam int TMR_W = 16;

    typedef enum logic [1:0] {
        DCMT_IDLE,
        DCMT_WAIT,
        DCMT_SEND
    } dcmt_resp_state_t;

endpackage : dcmt_pkg

// *** dcmt_fwd_delay.sv ***
// Repeater delay line: forwards a serial link sample a fixed number of cycles late.
// Assumes the input is already synchronised to mclk_in.
module dcmt_fwd_delay
    import dcmt_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    input  wire logic din_in,
    output logic      dout_out
);

    // The input synchroniser already spends four cycles of the repeater budget, so the
    // line is four stages shorter than the budget and the total stays within it.
    logic [FWD_DELAY_CYC-5:0] shift_reg;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= {shift_reg[FWD_DELAY_CYC-6:0], din_in};
        end
    end

    assign dout_out = shift_reg[FWD_DELAY_CYC-5];

endmodule : dcmt_fwd_delay

// *** dcmt_top.sv ***
// Daisy-chain message timing for one chain node: forwarding, response pacing,
// read latency, frame timeout and communication-loss reset.
// Assumes marker pulses come from a decoder on mclk_in; link lines are async.
// Every output comes from a flip-flop, so each pulse is clean for one cycle.
// Contract
// - Own consecutive responses spaced about 4.0 us.
// - Repeater adds at most 0.95 us delay.
// - Read response starts 4.0 to 9 us later.
// - Frame timeout restarts on each start marker.
// - Timeout expiry drops frame, awaits new reception.
// - 1024 ms without traffic resets the node.
module dcmt_top
    import dcmt_pkg::*;
#(
    parameter longint COMM_LOSS_CYCLES = COMM_LOSS_CYC
) (
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    input  wire logic link_up_in,
    input  wire logic link_dn_in,
    input  wire logic start_of_message_marker_in,
    input  wire logic end_of_message_marker_in,
    input  wire logic read_req_in,
    input  wire logic resp_pending_in,
    output logic      link_up_out,
    output logic      link_dn_out,
    output logic      frame_active_out,
    output logic      frame_drop_out,
    output logic      frame_done_out,
    output logic      resp_start_out,
    output logic      node_reset_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared arithmetic.

    // Interval counters run between zero and one less than the interval, counting up or down.
    function automatic logic [TMR_W-1:0] last_count(input int cycles);
        return TMR_W'(cycles - 1);
    endfunction : last_count

    // A synchronised level is taken only when the last two stages agree.
    function automatic logic settle(input logic [2:0] sync, input logic held);
        return (sync[1] == sync[2]) ? sync[2] : held;
    endfunction : settle

    ////////////////////////////////////////////////////////////////////////////
    // Link input synchronisers (three stages, change taken when 2nd and 3rd agree).

    logic [2:0] up_sync_reg;
    logic [2:0] dn_sync_reg;
    logic       up_clean_reg;
    logic       dn_clean_reg;

    // A glitch shorter than two samples never reaches the repeaters.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_sync_reg  <= 3'h0;
            up_clean_reg <= 1'b0;
        end else begin
            up_sync_reg  <= {up_sync_reg[1:0], link_up_in};
            up_clean_reg <= settle(up_sync_reg, up_clean_reg);
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dn_sync_reg  <= 3'h0;
            dn_clean_reg <= 1'b0;
        end else begin
            dn_sync_reg  <= {dn_sync_reg[1:0], link_dn_in};
            dn_clean_reg <= settle(dn_sync_reg, dn_clean_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Repeaters in both directions.
    // Delays add up along the chain, so each node keeps its share fixed and short.

    dcmt_fwd_delay u_fwd_up (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .din_in   (up_clean_reg),
        .dout_out (link_up_out)
    );

    dcmt_fwd_delay u_fwd_dn (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .din_in   (dn_clean_reg),
        .dout_out (link_dn_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame timeout.

    logic [TMR_W-1:0] frame_tmr_reg;
    logic             frame_reg;
    logic             drop_reg;
    logic             done_reg;

    // An end marker with no frame open is ignored rather than flagged.
    // The nominal timeout is used, which clears the shortest allowed one with margin.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_tmr_reg <= '0;
            frame_reg     <= 1'b0;
            drop_reg      <= 1'b0;
            done_reg      <= 1'b0;
        end else begin
            drop_reg <= 1'b0;
            done_reg <= 1'b0;
            if (start_of_message_marker_in) begin
                // Restart wins over any end or expiry in the same cycle.
                frame_tmr_reg <= '0;
                frame_reg     <= 1'b1;
            end else if (frame_reg && end_of_message_marker_in) begin
                frame_reg <= 1'b0;
                done_reg  <= 1'b1;
            end else if (frame_reg) begin
                if (frame_tmr_reg == last_count(FRAME_TIMEOUT_CYC)) begin
                    frame_reg <= 1'b0;
                    drop_reg  <= 1'b1;
                end else begin
                    frame_tmr_reg <= frame_tmr_reg + 1'b1;
                end
            end
        end
    end

    assign frame_active_out = frame_reg;
    assign frame_drop_out   = drop_reg;
    assign frame_done_out   = done_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Response pacing: read latency, then fixed spacing between own responses.
    // The typical latency is used, leaving margin at both ends of the allowed window.
    // A read that arrives while a response is under way is ignored.

    dcmt_resp_state_t resp_state_reg;
    logic [TMR_W-1:0] resp_tmr_reg;
    logic             resp_go_reg;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            resp_state_reg <= DCMT_IDLE;
            resp_tmr_reg   <= '0;
            resp_go_reg    <= 1'b0;
        end else begin
            resp_go_reg <= 1'b0;
            case (resp_state_reg)
                DCMT_IDLE: begin
                    if (read_req_in) begin
                        resp_tmr_reg   <= last_count(READ_LAT_CYC);
                        resp_state_reg <= DCMT_WAIT;
                    end
                end
                DCMT_WAIT: begin
                    if (resp_tmr_reg == '0) begin
                        resp_go_reg    <= 1'b1;
                        resp_tmr_reg   <= last_count(RESP_SPACING_CYC);
                        resp_state_reg <= DCMT_SEND;
                    end else begin
                        resp_tmr_reg <= resp_tmr_reg - 1'b1;
                    end
                end
                DCMT_SEND: begin
                    if (resp_tmr_reg != '0) begin
                        resp_tmr_reg <= resp_tmr_reg - 1'b1;
                    end else if (resp_pending_in) begin
                        resp_go_reg  <= 1'b1;
                        resp_tmr_reg <= last_count(RESP_SPACING_CYC);
                    end else begin
                        resp_state_reg <= DCMT_IDLE;
                    end
                end
                default: begin
                    resp_state_reg <= DCMT_IDLE;
                end
            endcase
        end
    end

    assign resp_start_out = resp_go_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Communication-loss watchdog. Any marker counts as traffic.
    // Only a request is raised here; the node's own reset logic acts on it.

    // Sized from the count, so both the full figure and a short test value fit.
    localparam int LOSS_W = $clog2(COMM_LOSS_CYCLES + 1);

    logic [LOSS_W-1:0] loss_tmr_reg;
    logic              loss_rst_reg;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            loss_tmr_reg <= '0;
            loss_rst_reg <= 1'b0;
        end else begin
            loss_rst_reg <= 1'b0;
            if (start_of_message_marker_in || end_of_message_marker_in) begin
                loss_tmr_reg <= '0;
            end else if (loss_tmr_reg == LOSS_W'(COMM_LOSS_CYCLES - 1)) begin
                loss_tmr_reg <= '0;
                loss_rst_reg <= 1'b1;
            end else begin
                loss_tmr_reg <= loss_tmr_reg + 1'b1;
            end
        end
    end

    assign node_reset_out = loss_rst_reg;

endmodule : dcmt_top

// *** dcmt_props.sv ***
// Checker for the dcmt_top port timing.
// Assumes the single mclk_in domain; bound to dcmt_top below.
module dcmt_props
    import dcmt_pkg::*;
#(
    parameter longint COMM_LOSS_CYCLES = COMM_LOSS_CYC
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic link_up_in,
    input wire logic link_dn_in,
    input wire logic start_of_message_marker_in,
    input wire logic end_of_message_marker_in,
    input wire logic read_req_in,
    input wire logic resp_pending_in,
    input wire logic link_up_out,
    input wire logic link_dn_out,
    input wire logic frame_active_out,
    input wire logic frame_drop_out,
    input wire logic frame_done_out,
    input wire logic resp_start_out,
    input wire logic node_reset_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    logic [4:0]  up_reg;
    logic [12:0] fr_reg;
    longint      q_reg;
    wire mark = start_of_message_marker_in | end_of_message_marker_in;
    // The delay check waits for the line to fill after reset.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_reg <= 5'h00;
            fr_reg <= 13'h0000;
            q_reg <= 0;
        end else begin
            up_reg <= (up_reg == 5'h1F) ? up_reg : up_reg + 5'h01;
            fr_reg <= start_of_message_marker_in ? 13'h0001 : fr_reg + 13'h0001;
            q_reg <= (mark || node_reset_out) ? 1 : q_reg + 1;
        end
    end
    sequence s_start; start_of_message_marker_in; endsequence
    sequence s_spaced; resp_start_out ##99 resp_pending_in; endsequence
    // A level is forwarded only once it has held for two samples.
    fwd_up_a: assert property (up_reg > 5'h18
        && $past(link_up_in, 23) == $past(link_up_in, 22)
        |-> link_up_out == $past(link_up_in, 23)) else $error("up forward delay");
    fwd_dn_a: assert property (up_reg > 5'h18
        && $past(link_dn_in, 23) == $past(link_dn_in, 22)
        |-> link_dn_out == $past(link_dn_in, 23)) else $error("down forward delay");
    frame_open_a: assert property (s_start |=> frame_active_out) else $error("no open");
    frame_close_a: assert property (end_of_message_marker_in && frame_active_out
        && !start_of_message_marker_in |=> frame_done_out) else $error("no done");
    drop_time_a: assert property (frame_drop_out
        |-> fr_reg == 13'h186B && !frame_active_out) else $error("drop timing");
    resp_lat_a: assert property (resp_start_out |-> $past(read_req_in, 126)
        || $past(resp_start_out, 100)) else $error("response latency");
    resp_space_a: assert property (s_spaced |=> resp_start_out) else $error("spacing");
    comm_loss_a: assert property (node_reset_out |-> q_reg >= COMM_LOSS_CYCLES - 1
        && q_reg <= COMM_LOSS_CYCLES + 1) else $error("watchdog timing");
endmodule : dcmt_props

bind dcmt_top dcmt_props #(.COMM_LOSS_CYCLES(COMM_LOSS_CYCLES)) dcmt_props_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .link_up_in(link_up_in), .link_dn_in(link_dn_in),
    .start_of_message_marker_in(start_of_message_marker_in),
    .end_of_message_marker_in(end_of_message_marker_in), .read_req_in(read_req_in),
    .resp_pending_in(resp_pending_in), .link_up_out(link_up_out), .link_dn_out(link_dn_out),
    .frame_active_out(frame_active_out), .frame_drop_out(frame_drop_out),
    .frame_done_out(frame_done_out), .resp_start_out(resp_start_out),
    .node_reset_out(node_reset_out));

// *** dcmt_host.sv ***
// Host side model: marker and read request pulses.
// Assumes cyc_in counts mclk_in edges in the bench.
module dcmt_host #(
    parameter int GAP = 100,
    parameter int WU  = 18750
) (
    input  wire logic        mclk_in,
    input  wire logic [31:0] cyc_in,
    output logic             start_mark_out = 1'b0,
    output logic             end_mark_out   = 1'b0,
    output logic             req_out        = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic send(input logic [2:0] sel, output logic [31:0] at);
        repeat (GAP) @(posedge mclk_in);
        at = cyc_in;
        {start_mark_out, end_mark_out, req_out} <= sel;
        @(posedge mclk_in);
        {start_mark_out, end_mark_out, req_out} <= 3'h0;
    endtask : send
    task automatic wake(input int nodes);
        repeat (nodes * WU) @(posedge mclk_in);
    endtask : wake
    task automatic rest(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : rest
endmodule : dcmt_host

// *** tb_top.sv ***
// Bench for dcmt_top: frames, reads, random link traffic, watchdog.
// Assumes dcmt_host drives markers and requests.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint WD = 20000;
    logic mclk_in = 1'b0, rstn_in = 1'b0, up = 1'b0, dn = 1'b0, pend = 1'b0;
    logic start_mark, end_mark, req, drop, done, rsp, nrst;
    logic [31:0] cyc = 32'h0, lfsr = 32'hEAAD8928, at;
    logic [35:0] q[$], n;
    int miscompares = 0, checks = 0;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    always #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc <= cyc + 32'h1;
        lfsr <= nx(lfsr);
        up <= lfsr[3];
        dn <= lfsr[9];
        if (cyc == 32'h15F90) begin
            miscompares++;
            give_verdict();
        end
    end
    // Each pulse takes the oldest note: one-hot kind, then the cycle seen.
    always @(posedge mclk_in) begin
        if (rstn_in && (done | drop | rsp | nrst)) begin
            n = (q.size() != 0) ? q.pop_front() : '1;
            chk(32'({done, drop, rsp, nrst}), 32'(n[35:32]));
            if (!nrst) chk(cyc, n[31:0]);
        end
    end
    dcmt_host dcmt_host_i (.mclk_in(mclk_in), .cyc_in(cyc), .start_mark_out(start_mark),
        .end_mark_out(end_mark), .req_out(req));
    dcmt_top #(.COMM_LOSS_CYCLES(WD)) dcmt_top_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .link_up_in(up), .link_dn_in(dn), .start_of_message_marker_in(start_mark),
        .end_of_message_marker_in(end_mark), .read_req_in(req), .resp_pending_in(pend),
        .link_up_out(), .link_dn_out(), .frame_active_out(), .frame_drop_out(drop),
        .frame_done_out(done), .resp_start_out(rsp), .node_reset_out(nrst));
    initial begin
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        dcmt_host_i.send(3'h4, at);
        dcmt_host_i.send(3'h2, at);
        q.push_back({4'h8, at + 32'd2});
        dcmt_host_i.wake(1);
        dcmt_host_i.send(3'h2, at);
        dcmt_host_i.send(3'h4, at);
        dcmt_host_i.rest(2900);
        dcmt_host_i.send(3'h4, at);
        q.push_back({4'h4, at + 32'd6252});
        dcmt_host_i.rest(6400);
        for (int i = 0; i < 2; i++) begin
            pend <= (i == 0);
            dcmt_host_i.send(3'h1, at);
            q.push_back({4'h2, at + 32'd127});
            if (i == 0) q.push_back({4'h2, at + 32'd227});
            dcmt_host_i.send(3'h1, at);
            dcmt_host_i.rest(150);
            pend <= 1'b0;
            dcmt_host_i.rest(250);
        end
        q.push_back({4'h1, 32'h0});
        dcmt_host_i.rest(int'(WD) - 6000);
        chk(32'(q.size()), 32'h0);
        give_verdict();
    end
endmodule : tb_top
